/* design/crb_pkg.sv */
// Constants for the per-channel register bank: offsets, masks, resets and
// the layout of the atomic multi-byte fields.
// Assumes the serial port engine hands over one byte access per cycle.
package crb_pkg;

  localparam int unsigned ADDR_W   = 11;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_CFG  = 13;
  localparam int unsigned NUM_FLD  = 4;
  localparam int unsigned FLD_MAXB = 5;

  localparam logic [10:0] ADDR_TOP      = 11'h6ff;
  localparam logic [10:0] ADDR_BANK_SEL = 11'h000;
  localparam logic [10:0] ADDR_LOCK_SR  = 11'h048;

  // Plain configuration registers: offset, writable bits, reset value
  localparam logic [NUM_CFG-1:0][10:0] CFG_ADDR = {
    11'h01b, 11'h015, 11'h014, 11'h013, 11'h012, 11'h00f, 11'h00e,
    11'h00d, 11'h00c, 11'h00b, 11'h00a, 11'h009, 11'h000};
  localparam logic [NUM_CFG-1:0][7:0] CFG_MASK = {
    8'he3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h07, 8'h07, 8'h11, 8'h7f, 8'hbf, 8'h01};
  localparam logic [NUM_CFG-1:0][7:0] CFG_RST = '0;
  localparam int unsigned IDX_BANK_SEL = 0;

  // Lock status register bit layout
  localparam int unsigned BIT_ALK     = 0;
  localparam int unsigned BIT_ALKL    = 1;
  localparam int unsigned BIT_ALKIE   = 2;
  localparam int unsigned BIT_ADLK    = 3;
  localparam int unsigned BIT_ALK2    = 4;
  localparam int unsigned BIT_ALK2L   = 5;
  localparam int unsigned BIT_ALK2IE  = 6;

  // Edge that sets each latched bit: 2'b01 rise, 2'b10 fall, 2'b11 either
  localparam logic [1:0] EDGE_ALK  = 2'h2;
  localparam logic [1:0] EDGE_ALK2 = 2'h3;

  // Multi-byte fields: 0 freq offset, 1 phase offset, 2 measured freq, 3 measured phase
  localparam int unsigned FLD_FREQ_OFS  = 0;
  localparam int unsigned FLD_PHASE_OFS = 1;
  localparam int unsigned FLD_MEAS_FREQ = 2;
  localparam int unsigned FLD_MEAS_PH   = 3;
  localparam logic [NUM_FLD-1:0][10:0] FLD_BASE = {11'h07d, 11'h065, 11'h1a8, 11'h1a0};
  localparam logic [NUM_FLD-1:0][2:0]  FLD_LEN  = {3'h4, 3'h4, 3'h4, 3'h5};
  localparam logic [NUM_FLD-1:0]       FLD_WR   = 4'h3;
  localparam logic [39:0] FREQ_OFS_RST  = 40'h0;
  localparam logic [31:0] PHASE_OFS_RST = 32'h0;

  typedef struct packed {
    logic [NUM_CFG-1:0][7:0] cfg;
    logic [39:0]             freq_ofs;
    logic [31:0]             phase_ofs;
    logic [31:0]             wr_xfer;
    logic [39:0]             rd_xfer;
    logic                    alk_l;
    logic                    alk2_l;
    logic                    alk_prev;
    logic                    alk2_prev;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    ee_rd;
    logic                    ee_wr;
    logic [10:0]             ee_addr;
    logic [7:0]              ee_wdata;
    logic [1:0]              lock_ie;
    logic                    irq;
  } crb_state_s;

endpackage : crb_pkg

/* design/crb_bank.sv */
// Per-channel register bank behind the channel's own serial slave port.
// Assumes a serial engine on core_clk presenting single-cycle byte accesses,
// an EEPROM array answering with ee_rvalid, and PLL status on core_clk.
//
// Function
// - Each channel decodes its own address space 000h to 6FFh independently.
// - Bit 7 of every register is the MSb, bit 0 the LSb.
// - Read-only fields ignore writes; other non-reserved fields are read-write.
// - Real-time status bits are read-only and show the live source level.
// - Latched bits set on the chosen source edge, clear on write-one only.
// - A latched bit with its enable set raises the interrupt request.
// - Reset returns every configuration field to its default.
// - Lower bytes go to the write transfer register; last byte commits all.
// - Reads during a pending partial write return the committed value.
// - Reading the lowest byte snapshots the field; later bytes read the snapshot.
// - Writes during a multi-byte read overwrite the read transfer register bytes.
// - One write and one read transfer register shared by all fields.
// - Bank-select bit clear maps registers at 1 and up, set maps EEPROM.
// - The bank-select register stays at address zero in both banks.
// - Each channel's bank sits behind its own independent slave port.
`timescale 1ns/100ps
module crb_bank #(
  parameter int unsigned ADDR_W = crb_pkg::ADDR_W  // Register address width
) (
  input  wire logic                  core_clk,      // 10 MHz core clock
  input  wire logic                  rst_n,         // Async reset, active low
  input  wire logic                  acc_wr,        // Byte write strobe from port engine
  input  wire logic                  acc_rd,        // Byte read strobe from port engine
  input  wire logic [ADDR_W-1:0]     acc_addr,      // Register address
  input  wire logic [7:0]            acc_wdata,     // Write byte
  output logic      [7:0]            acc_rdata,     // Read byte
  output logic                       acc_rvalid,    // Read byte valid pulse
  input  wire logic                  alk_src,       // APLL lock level
  input  wire logic                  adlk_src,      // APLL digital lock level
  input  wire logic                  alk2_src,      // APLL second lock level
  input  wire logic [31:0]           meas_freq,     // Measured frequency
  input  wire logic [31:0]           meas_phase,    // Measured phase
  output logic                       ee_rd,         // EEPROM read pulse
  output logic                       ee_wr,         // EEPROM write pulse
  output logic      [ADDR_W-1:0]     ee_addr,       // EEPROM address
  output logic      [7:0]            ee_wdata,      // EEPROM write byte
  input  wire logic [7:0]            ee_rdata,      // EEPROM read byte
  input  wire logic                  ee_rvalid,     // EEPROM read byte valid
  output logic      [crb_pkg::NUM_CFG*8-1:0] cfg_out, // Configuration registers
  output logic      [39:0]           freq_ofs,      // Committed frequency offset
  output logic      [31:0]           phase_ofs,     // Committed phase offset
  output logic                       bank_sel,      // EEPROM bank mapped
  output logic                       irq_req        // Interrupt request level
);

  //////////////////////////////////////////////////////////////////////////////
  // Parameter check

  if (ADDR_W != crb_pkg::ADDR_W) begin : g_bad_width
    $error("crb_bank: address width must match the channel map");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State

  crb_pkg::crb_state_s st_ff;
  crb_pkg::crb_state_s nxt_st;

  logic        ev_alk;
  logic        ev_alk2;
  logic        in_map;
  logic        to_eeprom;
  logic [39:0] fld_val;
  logic [2:0]  fld_byte;
  logic [1:0]  fld_sel;
  logic        fld_hit;
  logic [7:0]  lock_sr;

  // Source edges, per bit edge choice
  assign ev_alk  = (crb_pkg::EDGE_ALK[0] & alk_src & ~st_ff.alk_prev) |
                   (crb_pkg::EDGE_ALK[1] & ~alk_src & st_ff.alk_prev);
  assign ev_alk2 = (crb_pkg::EDGE_ALK2[0] & alk2_src & ~st_ff.alk2_prev) |
                   (crb_pkg::EDGE_ALK2[1] & ~alk2_src & st_ff.alk2_prev);

  assign in_map    = acc_addr <= crb_pkg::ADDR_TOP;
  assign to_eeprom = st_ff.cfg[crb_pkg::IDX_BANK_SEL][0] &&
                     acc_addr != crb_pkg::ADDR_BANK_SEL;

  // Real-time bits are live; reserved bit 7 reads zero
  always_comb begin
    lock_sr                      = 8'h00;
    lock_sr[crb_pkg::BIT_ALK]    = alk_src;
    lock_sr[crb_pkg::BIT_ADLK]   = adlk_src;
    lock_sr[crb_pkg::BIT_ALK2]   = alk2_src;
    lock_sr[crb_pkg::BIT_ALKL]   = st_ff.alk_l;
    lock_sr[crb_pkg::BIT_ALK2L]  = st_ff.alk2_l;
    lock_sr[crb_pkg::BIT_ALKIE]  = st_ff.lock_ie[0];
    lock_sr[crb_pkg::BIT_ALK2IE] = st_ff.lock_ie[1];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multi-byte field decode

  always_comb begin
    fld_hit  = 1'b0;
    fld_sel  = 2'h0;
    fld_byte = 3'h0;
    for (int f = 0; f < crb_pkg::NUM_FLD; f++) begin
      if (acc_addr >= crb_pkg::FLD_BASE[f] &&
          acc_addr < crb_pkg::FLD_BASE[f] + 11'(crb_pkg::FLD_LEN[f])) begin
        fld_hit  = 1'b1;
        fld_sel  = 2'(f);
        fld_byte = 3'(acc_addr - crb_pkg::FLD_BASE[f]);
      end
    end
    unique case (fld_sel)
      2'h0:    fld_val = st_ff.freq_ofs;
      2'h1:    fld_val = {8'h00, st_ff.phase_ofs};
      2'h2:    fld_val = {8'h00, meas_freq};
      default: fld_val = {8'h00, meas_phase};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rvalid    = 1'b0;
    nxt_st.ee_rd     = 1'b0;
    nxt_st.ee_wr     = 1'b0;
    nxt_st.alk_prev  = alk_src;
    nxt_st.alk2_prev = alk2_src;

    // Host write path
    if (acc_wr && in_map) begin
      if (to_eeprom) begin
        nxt_st.ee_wr    = 1'b1;
        nxt_st.ee_addr  = acc_addr;
        nxt_st.ee_wdata = acc_wdata;
      end else if (fld_hit) begin
        if (crb_pkg::FLD_WR[fld_sel]) begin
          nxt_st.rd_xfer[fld_byte*8 +: 8] = acc_wdata;
          if (fld_byte == crb_pkg::FLD_LEN[fld_sel] - 3'h1) begin
            if (fld_sel == 2'(crb_pkg::FLD_FREQ_OFS)) begin
              nxt_st.freq_ofs = {acc_wdata, st_ff.wr_xfer};
            end else begin
              nxt_st.phase_ofs = {acc_wdata, st_ff.wr_xfer[23:0]};
            end
          end else begin
            nxt_st.wr_xfer[fld_byte*8 +: 8] = acc_wdata;
          end
        end
      end else if (acc_addr == crb_pkg::ADDR_LOCK_SR) begin
        nxt_st.lock_ie[0] = acc_wdata[crb_pkg::BIT_ALKIE];
        nxt_st.lock_ie[1] = acc_wdata[crb_pkg::BIT_ALK2IE];
        if (acc_wdata[crb_pkg::BIT_ALKL]) begin
          nxt_st.alk_l = 1'b0;
        end
        if (acc_wdata[crb_pkg::BIT_ALK2L]) begin
          nxt_st.alk2_l = 1'b0;
        end
      end else begin
        for (int i = 0; i < crb_pkg::NUM_CFG; i++) begin
          if (acc_addr == crb_pkg::CFG_ADDR[i]) begin
            nxt_st.cfg[i] = acc_wdata & crb_pkg::CFG_MASK[i];
          end
        end
      end
    end

    // Events win over a clear in the same cycle
    if (ev_alk) begin
      nxt_st.alk_l = 1'b1;
    end
    if (ev_alk2) begin
      nxt_st.alk2_l = 1'b1;
    end

    // Host read path
    if (acc_rd) begin
      if (in_map && to_eeprom) begin
        nxt_st.ee_rd   = 1'b1;
        nxt_st.ee_addr = acc_addr;
      end else begin
        nxt_st.rvalid = 1'b1;
        nxt_st.rdata  = 8'h00;
        if (!in_map) begin
          nxt_st.rdata = 8'h00;
        end else if (fld_hit) begin
          if (fld_byte == 3'h0) begin
            nxt_st.rd_xfer = fld_val;
            nxt_st.rdata   = fld_val[7:0];
          end else begin
            nxt_st.rdata = st_ff.rd_xfer[fld_byte*8 +: 8];
          end
        end else if (acc_addr == crb_pkg::ADDR_LOCK_SR) begin
          nxt_st.rdata = lock_sr;
        end else begin
          for (int i = 0; i < crb_pkg::NUM_CFG; i++) begin
            if (acc_addr == crb_pkg::CFG_ADDR[i]) begin
              nxt_st.rdata = st_ff.cfg[i];
            end
          end
        end
      end
    end
    if (ee_rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = ee_rdata;
    end

    nxt_st.irq = (nxt_st.alk_l & nxt_st.lock_ie[0]) |
                 (nxt_st.alk2_l & nxt_st.lock_ie[1]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.cfg       <= crb_pkg::CFG_RST;
      st_ff.freq_ofs  <= crb_pkg::FREQ_OFS_RST;
      st_ff.phase_ofs <= crb_pkg::PHASE_OFS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign acc_rdata  = st_ff.rdata;
  assign acc_rvalid = st_ff.rvalid;
  assign ee_rd      = st_ff.ee_rd;
  assign ee_wr      = st_ff.ee_wr;
  assign ee_addr    = st_ff.ee_addr;
  assign ee_wdata   = st_ff.ee_wdata;
  assign cfg_out    = st_ff.cfg;
  assign freq_ofs   = st_ff.freq_ofs;
  assign phase_ofs  = st_ff.phase_ofs;
  assign bank_sel   = st_ff.cfg[crb_pkg::IDX_BANK_SEL][0];
  assign irq_req    = st_ff.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_irq_follows_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_req == ((st_ff.alk_l & st_ff.lock_ie[0]) | (st_ff.alk2_l & st_ff.lock_ie[1])))
    else $error("interrupt request does not match latched bits and enables");

  a_latch_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev_alk |=> st_ff.alk_l)
    else $error("latched lock bit missed a source edge");

  a_latch_zero_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_ff.alk_l && !(acc_wr && !to_eeprom && acc_addr == crb_pkg::ADDR_LOCK_SR &&
     acc_wdata[crb_pkg::BIT_ALKL])) |=> st_ff.alk_l)
    else $error("latched lock bit cleared without a write of one");

  a_freq_commit_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(acc_wr && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[0] + 11'h004) |=>
    $stable(freq_ofs))
    else $error("frequency offset changed without its last byte written");

  a_freq_commit_val: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[0] + 11'h004) |=>
    freq_ofs == {$past(acc_wdata), $past(st_ff.wr_xfer)})
    else $error("frequency offset commit lost transfer bytes");

  a_snap_low_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[2]) |=>
    acc_rvalid && st_ff.rd_xfer[31:0] == $past(meas_freq) &&
    acc_rdata == $past(meas_freq[7:0]))
    else $error("measured frequency snapshot not taken on low byte read");

  a_ro_field_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && !to_eeprom && acc_addr >= crb_pkg::FLD_BASE[2] &&
     acc_addr < crb_pkg::FLD_BASE[2] + 11'(crb_pkg::FLD_LEN[2])) |=> $stable(st_ff.rd_xfer))
    else $error("write to read-only field altered the transfer register");

  a_bank_sel_home: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && acc_addr == crb_pkg::ADDR_BANK_SEL && !ee_rvalid) |=>
    acc_rvalid && !ee_rd && acc_rdata == {7'h00, bank_sel})
    else $error("bank select register not readable at address zero");

  a_eeprom_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && bank_sel && acc_addr != crb_pkg::ADDR_BANK_SEL && in_map) |=>
    ee_wr && ee_addr == $past(acc_addr) && $stable(cfg_out))
    else $error("write in EEPROM bank not routed to the EEPROM");

  a_live_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && !to_eeprom && acc_addr == crb_pkg::ADDR_LOCK_SR && !ee_rvalid) |=>
    acc_rdata[crb_pkg::BIT_ALK] == $past(alk_src) && acc_rdata[crb_pkg::BIT_ADLK] == $past(adlk_src) &&
    acc_rdata[crb_pkg::BIT_ALK2] == $past(alk2_src))
    else $error("status read does not show the live source levels");

  a_range_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && !in_map && !ee_rvalid) |=> acc_rvalid && acc_rdata == 8'h00)
    else $error("read above the channel map did not return zero");

  a_range_write_none: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && !in_map) |=> !ee_wr && $stable(cfg_out) && $stable(freq_ofs) && $stable(phase_ofs))
    else $error("write above the channel map changed state");

  a_committed_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[0] && !ee_rvalid) |=>
    acc_rdata == $past(freq_ofs[7:0]) && st_ff.rd_xfer == $past(freq_ofs))
    else $error("offset read did not return the committed value");

  a_phase_commit_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(acc_wr && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[1] + 11'(crb_pkg::FLD_LEN[1] - 3'h1)) |=>
    $stable(phase_ofs))
    else $error("phase offset changed without its last byte written");

  a_write_over_snap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[1] + 11'h001) |=>
    st_ff.rd_xfer[15:8] == $past(acc_wdata))
    else $error("write did not overwrite the read transfer byte");

  a_snap_later_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && !to_eeprom && acc_addr == crb_pkg::FLD_BASE[2] + 11'h001 && !ee_rvalid) |=>
    acc_rvalid && acc_rdata == $past(st_ff.rd_xfer[15:8]))
    else $error("later measured byte not taken from the snapshot");

  a_cfg_write_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_wr && !to_eeprom && acc_addr == crb_pkg::CFG_ADDR[1]) |=>
    cfg_out[15:8] == ($past(acc_wdata) & crb_pkg::CFG_MASK[1]))
    else $error("control write did not land with reserved bits dropped");

  a_eeprom_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    ee_rvalid |=> acc_rvalid && acc_rdata == $past(ee_rdata))
    else $error("EEPROM byte not forwarded to the read port");

  a_eeprom_read_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc_rd && bank_sel && acc_addr != crb_pkg::ADDR_BANK_SEL && in_map) |=>
    ee_rd && ee_addr == $past(acc_addr))
    else $error("read in EEPROM bank not routed to the EEPROM");

  a_latch2_either: assert property (@(posedge core_clk) disable iff (!rst_n)
    (alk2_src != st_ff.alk2_prev) |=> st_ff.alk2_l)
    else $error("second latched lock bit missed a source edge");

  a_latch_one_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_ff.alk_l && !ev_alk && acc_wr && !to_eeprom && acc_addr == crb_pkg::ADDR_LOCK_SR &&
     acc_wdata[crb_pkg::BIT_ALKL]) |=> !st_ff.alk_l)
    else $error("latched lock bit not cleared by a write of one");

  a_reset_defaults: assert property (@(posedge core_clk)
    !rst_n |-> cfg_out == crb_pkg::CFG_RST && freq_ofs == crb_pkg::FREQ_OFS_RST &&
    phase_ofs == crb_pkg::PHASE_OFS_RST && !irq_req)
    else $error("configuration not at defaults while reset is held");

endmodule : crb_bank

/* sim/crb_host_model.sv */
// Host processor stand-in driving the bank's byte access port.
// Assumes a free-running core_clk; every request changes at the falling edge.
`timescale 1ns/100ps
module crb_host_model (
  input  wire logic       core_clk,   // Core clock
  output logic            acc_wr,     // Write strobe
  output logic            acc_rd,     // Read strobe
  output logic [10:0]     acc_addr,   // Byte address
  output logic [7:0]      acc_wdata,  // Write byte
  input  wire logic [7:0] acc_rdata,  // Read byte
  input  wire logic       acc_rvalid  // Read answer
);
  initial begin
    acc_wr    = 1'b0;
    acc_rd    = 1'b0;
    acc_addr  = 11'h000;
    acc_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Released address and data are inverted so stale values never match
  task automatic wr_byte(input logic [10:0] a, input logic [7:0] d);
    @(negedge core_clk);
    acc_addr  = a;
    acc_wdata = d;
    acc_wr    = 1'b1;
    @(negedge core_clk);
    acc_wr    = 1'b0;
    acc_addr  = ~a;
    acc_wdata = ~d;
  endtask : wr_byte

  // Single process and ascending order are up to the caller
  task automatic rd_byte(input logic [10:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge core_clk);
    acc_addr = a;
    acc_rd   = 1'b1;
    @(negedge core_clk);
    acc_rd   = 1'b0;
    acc_addr = ~a;
    for (int i = 0; i < 8 && !ok; i++) begin
      if (acc_rvalid === 1'b1) begin
        d  = acc_rdata;
        ok = 1'b1;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask : rd_byte
endmodule : crb_host_model

/* sim/crb_bank_tb_top.sv */
// Self-checking bench for the register bank with a reference model.
// Assumes the host model on the access port and an EEPROM stand-in here.
`timescale 1ns/100ps
module crb_bank_tb_top;
  logic          core_clk, rst_n, acc_wr, acc_rd, acc_rvalid, alk_src, adlk_src, alk2_src;
  logic [10:0]   acc_addr, ee_addr;
  logic [7:0]    acc_wdata, acc_rdata, ee_wdata;
  logic [31:0]   meas_freq, meas_phase, phase_ofs;
  logic          ee_rd, ee_wr, bank_sel, irq_req;
  logic          ee_rvalid = 1'b0;
  logic [7:0]    ee_rdata  = 8'h00;
  logic [103:0]  cfg_out;
  logic [39:0]   freq_ofs;
  logic [7:0]    ref_cfg [13];
  logic [18:0]   ee_last   = '0;
  int            error_cnt, checks_done;
  int            ee_wr_cnt = 0;

  crb_bank crb_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .alk_src(alk_src), .adlk_src(adlk_src), .alk2_src(alk2_src), .meas_freq(meas_freq),
    .meas_phase(meas_phase), .ee_rd(ee_rd), .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid), .cfg_out(cfg_out), .freq_ofs(freq_ofs),
    .phase_ofs(phase_ofs), .bank_sel(bank_sel), .irq_req(irq_req));
  crb_host_model crb_host_model_inst (.core_clk(core_clk), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // EEPROM stand-in: answers half a cycle after a read pulse rises, data busy otherwise
  always @(negedge core_clk) begin
    ee_rvalid <= ee_rd;
    ee_rdata  <= (ee_rd === 1'b1) ? (ee_addr[7:0] ^ 8'h5a) : ~ee_rdata;
    if (ee_wr === 1'b1) begin
      ee_wr_cnt <= ee_wr_cnt + 1;
      ee_last   <= {ee_addr, ee_wdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    crb_host_model_inst.wr_byte(a, d);
  endtask : wr

  task automatic rdchk(input logic [10:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit         ok;
    crb_host_model_inst.rd_byte(a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t no read answer at %0h", $time, a);
      tally_and_finish();
    end
    chk({32'h0, d}, {32'h0, exp}, what);
  endtask : rdchk

  task automatic mb_wr(input logic [10:0] base, input int n, input logic [39:0] v);
    for (int b = 0; b < n; b++) begin
      wr(base + 11'(b), v[8*b +: 8]);
    end
  endtask : mb_wr

  task automatic mb_rd(input logic [10:0] base, input int n, input logic [39:0] v, input string what);
    for (int b = 0; b < n; b++) begin
      rdchk(base + 11'(b), v[8*b +: 8], what);
    end
  endtask : mb_rd

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [39:0] v;
    logic [39:0] w;
    logic [31:0] p;
    {rst_n, alk_src, adlk_src, alk2_src, meas_freq, meas_phase} = '0;
    {error_cnt, checks_done} = '0;
    void'($urandom(32'h8586fde8));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 13; i++) begin
      ref_cfg[i] = 8'h00;
      rdchk(crb_pkg::CFG_ADDR[i], ref_cfg[i], "cfg reset");
    end
    for (int i = 1; i < 13; i++) begin
      ref_cfg[i] = 8'($urandom()) & crb_pkg::CFG_MASK[i];
      wr(crb_pkg::CFG_ADDR[i], ref_cfg[i]);
    end
    for (int i = 1; i < 13; i++) begin
      rdchk(crb_pkg::CFG_ADDR[i], ref_cfg[i], "cfg rw");
      chk(cfg_out[8*i +: 8], ref_cfg[i], "cfg out");
    end
    rdchk(11'h700, 8'h00, "out of range");
    $display("test config done");
    v = {8'($urandom()), 32'($urandom())};
    mb_wr(11'h1a0, 4, v);
    chk(freq_ofs, 40'h0, "freq held");
    rdchk(11'h1a0, 8'h00, "committed read");
    wr(11'h1a4, v[39:32]);
    chk(freq_ofs, v, "freq commit");
    mb_rd(11'h1a0, 5, v, "freq read");
    p = $urandom();
    mb_wr(11'h1a8, 4, {8'h0, p});
    chk(phase_ofs, {8'h0, p}, "phase commit");
    mb_rd(11'h1a8, 4, {8'h0, p}, "phase read");
    rdchk(11'h1a8, p[7:0], "snap low");
    wr(11'h1a9, 8'h3c);
    rdchk(11'h1a9, 8'h3c, "write over snapshot");
    w = {8'($urandom()), 32'($urandom())};
    mb_wr(11'h1a0, 2, w);
    p = $urandom();
    mb_wr(11'h1a8, 4, {8'h0, p});
    wr(11'h1a4, w[39:32]);
    // Last phase byte commits directly, so transfer byte 3 still holds the first offset write
    chk(freq_ofs, {w[39:32], v[31:24], p[23:0]}, "shared transfer");
    $display("test multibyte write done");
    for (int f = 0; f < 2; f++) begin
      v = {8'h0, 32'($urandom())};
      if (f == 0) meas_freq = v[31:0];
      else meas_phase = v[31:0];
      rdchk(f ? 11'h07d : 11'h065, v[7:0], "meas low");
      meas_freq  = ~meas_freq;
      meas_phase = ~meas_phase;
      wr(f ? 11'h07e : 11'h066, ~v[15:8]);
      mb_rd(f ? 11'h07e : 11'h066, 3, v >> 8, "meas snapshot");
    end
    $display("test measured done");
    alk_src  = 1'b1;
    adlk_src = 1'b1;
    rdchk(11'h048, 8'h09, "live bits");
    alk_src = 1'b0;
    rdchk(11'h048, 8'h0a, "falling latch");
    wr(11'h048, 8'h08);
    rdchk(11'h048, 8'h0a, "write zero keeps");
    chk(irq_req, 1'b0, "irq masked");
    wr(11'h048, 8'h04);
    repeat (2) @(negedge core_clk);
    chk(irq_req, 1'b1, "irq enabled");
    wr(11'h048, 8'h06);
    repeat (2) @(negedge core_clk);
    chk(irq_req, 1'b0, "irq cleared");
    alk2_src = 1'b1;
    rdchk(11'h048, 8'h3c, "either edge latch");
    wr(11'h048, 8'h64);
    alk2_src = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(irq_req, 1'b1, "second enable");
    $display("test status done");
    wr(11'h000, 8'h01);
    chk(bank_sel, 1'b1, "bank set");
    wr(11'h701, 8'h00);
    rdchk(11'h009, 8'h53, "eeprom read");
    rdchk(11'h000, 8'h01, "select stays");
    wr(11'h00a, 8'h77);
    repeat (2) @(negedge core_clk);
    chk(ee_wr_cnt, 1, "eeprom write count");
    chk(ee_last, {11'h00a, 8'h77}, "eeprom write");
    chk(cfg_out[23:16], ref_cfg[2], "cfg untouched");
    wr(11'h000, 8'h00);
    rdchk(11'h00a, ref_cfg[2], "bank back");
    $display("test bank done");
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({39'h0, |cfg_out}, 40'h0, "cfg reset again");
    chk(freq_ofs, 40'h0, "freq reset");
    chk({8'h0, phase_ofs}, 40'h0, "phase reset");
    chk({39'h0, irq_req}, 40'h0, "irq reset");
    rst_n = 1'b1;
    rdchk(11'h009, 8'h00, "cfg after reset");
    rdchk(11'h1a0, 8'h00, "freq after reset");
    $display("test reset done");
    tally_and_finish();
  end
endmodule : crb_bank_tb_top
